// ==== rtl/wpwt_pkg.sv ====
// package of the window / pulse width timer: register map, field layout,
// reset values, start and mode encodings, prescaler rates.
// assumes an apb slave with 32-bit data, one aligned word per register.
package wpwt_pkg;

  // register byte offsets
  localparam logic [7:0] WPWT_OFF_CTRL   = 8'h00;  // first_timer_control_reg
  localparam logic [7:0] WPWT_OFF_CMP    = 8'h04;  // compare_limit_reg
  localparam logic [7:0] WPWT_OFF_CAP    = 8'h08;  // capture_result_reg, read only
  localparam logic [7:0] WPWT_OFF_CNT    = 8'h0c;  // live up-counter, read only
  localparam logic [7:0] WPWT_OFF_STAT   = 8'h10;  // run state, read only

  // control field positions
  localparam int WPWT_MODE_BIT  = 0;  // 0 window, 1 pulse width
  localparam int WPWT_CLK_LSB   = 1;  // 2-bit source clock select
  localparam int WPWT_START_LSB = 4;  // 2-bit start_control_field
  localparam int WPWT_MCAP_BIT  = 6;  // capture_edge_mode_bit
  localparam int WPWT_POL_BIT   = 7;  // edge_polarity_select
  localparam int WPWT_SCAP_BIT  = 8;  // soft_capture_bit, write only

  // reset values
  localparam logic [7:0]  WPWT_CTRL_RST = 8'h00;
  localparam logic [15:0] WPWT_CMP_RST  = 16'hffff;
  localparam logic [15:0] WPWT_CAP_RST  = 16'h0000;

  // mode select values
  localparam logic WPWT_MODE_WINDOW = 1'b0;
  localparam logic WPWT_MODE_PULSE  = 1'b1;
  localparam logic WPWT_MCAP_DOUBLE = 1'b0;

  // source clock select: divide by 2^11, 2^7, 2^3; 11 selects nothing here
  localparam logic [1:0] WPWT_CLK_DIV_SLOW = 2'b00;
  localparam logic [1:0] WPWT_CLK_DIV_MID  = 2'b01;
  localparam logic [1:0] WPWT_CLK_DIV_FAST = 2'b10;
  localparam int WPWT_SHIFT_SLOW = 11;
  localparam int WPWT_SHIFT_MID  = 7;
  localparam int WPWT_SHIFT_FAST = 3;

  typedef enum logic [1:0] {
    WPWT_START_STOP = 2'b00,
    WPWT_START_CMD  = 2'b01,
    WPWT_START_RSVD = 2'b10,
    WPWT_START_EXT  = 2'b11
  } wpwt_start_t;

  typedef enum logic [1:0] {
    WPWT_ST_ARMED  = 2'b00,
    WPWT_ST_FIRST  = 2'b01,
    WPWT_ST_SECOND = 2'b10
  } wpwt_state_t;

endpackage

// ==== rtl/wpwt_prescaler.sv ====
// prescaler of the window / pulse width timer: one-cycle count enables.
// assumes the single system clock; no external clock source is offered.
`timescale 1ns/100ps
module wpwt_prescaler
  import wpwt_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [1:0] sel,
  output logic            tick
);

  logic [10:0] div_ff;

  // free running divider, restarts on reset only
  always_ff @(posedge clk) begin
    if (rst) begin
      div_ff <= 11'h000;
    end else begin
      div_ff <= div_ff + 11'h001;
    end
  end

  // tick when the low bits of the selected rate are all ones
  always_comb begin
    case (sel)
      WPWT_CLK_DIV_SLOW: tick = &div_ff[WPWT_SHIFT_SLOW-1:0];
      WPWT_CLK_DIV_MID:  tick = &div_ff[WPWT_SHIFT_MID-1:0];
      WPWT_CLK_DIV_FAST: tick = &div_ff[WPWT_SHIFT_FAST-1:0];
      default:           tick = 1'b0;  // external clock not served here
    endcase
  end

endmodule // wpwt_prescaler

// ==== rtl/wpwt_timer.sv ====
// window / pulse width timer: 16-bit up-counter, compare and capture,
// apb register slave and a one-cycle match / capture interrupt pulse.
// assumes event_window_pin is already synchronous to clk.
`timescale 1ns/100ps

module wpwt_timer
  import wpwt_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        event_window_pin,
  output logic             counter_match_irq
);

  logic [7:0]  ctrl_ff;
  logic [15:0] cmp_ff;
  logic [15:0] cap_ff;
  logic [15:0] cnt_ff;
  logic [31:0] prdata_ff;
  logic        pin_prev_ff;
  logic        irq_ff;
  wpwt_state_t state_ff;

  logic [15:0] nxt_cnt;
  logic [15:0] nxt_cap;
  logic        nxt_irq;
  wpwt_state_t nxt_state;

  logic        wr_acc;
  logic        rd_setup;
  logic        addr_ok;
  logic        scap_wr;
  logic        tick;
  logic        mode;
  logic        pol;
  logic        single;
  wpwt_start_t start;
  logic        pin_act;
  logic        rise;
  logic        fall;
  logic        trig_edge;
  logic        opp_edge;
  logic [15:0] cnt_inc;
  logic [31:0] rd_val;

  // field views of the control register
  assign mode   = ctrl_ff[WPWT_MODE_BIT];
  assign pol    = ctrl_ff[WPWT_POL_BIT];
  assign single = ctrl_ff[WPWT_MCAP_BIT];
  assign start  = wpwt_start_t'(ctrl_ff[WPWT_START_LSB +: 2]);

  // apb decode; zero wait states keep the bus model simple
  assign wr_acc   = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign addr_ok  = (paddr == WPWT_OFF_CTRL) || (paddr == WPWT_OFF_CMP) ||
                    (paddr == WPWT_OFF_CAP)  || (paddr == WPWT_OFF_CNT) ||
                    (paddr == WPWT_OFF_STAT);
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~addr_ok;
  assign prdata   = prdata_ff;
  assign scap_wr  = wr_acc & (paddr == WPWT_OFF_CTRL) & pwdata[WPWT_SCAP_BIT];
  assign counter_match_irq = irq_ff;

  // prescaled count enable; only internal rates exist
  wpwt_prescaler u_prescaler (
    .clk  (clk),
    .rst  (rst),
    .sel  (ctrl_ff[WPWT_CLK_LSB +: 2]),
    .tick (tick)
  );

  // pin polarity and edges; pin is sampled as a synchronous input
  assign pin_act   = event_window_pin ^ pol;
  assign rise      = event_window_pin & ~pin_prev_ff;
  assign fall      = ~event_window_pin & pin_prev_ff;
  assign trig_edge = pol ? fall : rise;
  assign opp_edge  = pol ? rise : fall;
  assign cnt_inc   = cnt_ff + 16'h0001;

  // previous pin level for edge detection
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_prev_ff <= 1'b0;
    end else begin
      pin_prev_ff <= event_window_pin;
    end
  end

  // control register; soft capture bit is a pulse and never stored
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_ff <= WPWT_CTRL_RST;
    end else if (wr_acc && paddr == WPWT_OFF_CTRL) begin
      ctrl_ff <= pwdata[7:0];
    end
  end

  // compare limit, full 16 bits in one write
  always_ff @(posedge clk) begin
    if (rst) begin
      cmp_ff <= WPWT_CMP_RST;
    end else if (wr_acc && paddr == WPWT_OFF_CMP) begin
      cmp_ff <= pwdata[15:0];
    end
  end

  // counter, capture and sequencing for both modes
  always_comb begin
    nxt_cnt   = cnt_ff;
    nxt_cap   = cap_ff;
    nxt_irq   = 1'b0;
    nxt_state = state_ff;
    if (start == WPWT_START_STOP) begin
      nxt_cnt   = 16'h0000;
      nxt_state = WPWT_ST_ARMED;
    end else if (mode == WPWT_MODE_WINDOW) begin
      nxt_state = WPWT_ST_ARMED;
      // count only while the window is open
      if (tick && pin_act) begin
        if (cnt_inc == cmp_ff) begin
          nxt_cnt = 16'h0000;
          nxt_irq = 1'b1;
        end else begin
          nxt_cnt = cnt_inc;
        end
      end
      if (scap_wr) begin
        nxt_cap = cnt_ff;
      end
    end else begin
      case (state_ff)
        WPWT_ST_ARMED: begin
          // hold until the trigger edge under external start
          if (start == WPWT_START_EXT && trig_edge) begin
            nxt_cnt   = 16'h0000;
            nxt_state = WPWT_ST_FIRST;
          end
        end
        WPWT_ST_FIRST: begin
          if (tick) begin
            nxt_cnt = cnt_inc;
          end
          if (opp_edge) begin
            nxt_cap = cnt_ff;
            nxt_irq = 1'b1;
            if (single) begin
              nxt_cnt   = 16'h0000;
              nxt_state = WPWT_ST_ARMED;
            end else begin
              nxt_state = WPWT_ST_SECOND;
            end
          end
        end
        WPWT_ST_SECOND: begin
          if (tick) begin
            nxt_cnt = cnt_inc;
          end
          // period end: recapture, then this edge opens the next period
          if (trig_edge) begin
            nxt_cap   = cnt_ff;
            nxt_irq   = 1'b1;
            nxt_cnt   = 16'h0000;
            nxt_state = WPWT_ST_FIRST;
          end
        end
        default: begin
          nxt_state = WPWT_ST_ARMED;
        end
      endcase
      // leaving external start drops the measurement, count is kept
      if (start != WPWT_START_EXT) begin
        nxt_state = WPWT_ST_ARMED;
      end
    end
  end

  // counter and measurement state
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_ff   <= 16'h0000;
      state_ff <= WPWT_ST_ARMED;
    end else begin
      cnt_ff   <= nxt_cnt;
      state_ff <= nxt_state;
    end
  end

  // capture result keeps its value across stop
  always_ff @(posedge clk) begin
    if (rst) begin
      cap_ff <= WPWT_CAP_RST;
    end else begin
      cap_ff <= nxt_cap;
    end
  end

  // one-cycle interrupt pulse toward the cpu
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= nxt_irq;
    end
  end

  // read mux; unmapped addresses read zero and flag pslverr
  always_comb begin
    case (paddr)
      WPWT_OFF_CTRL: rd_val = {24'h000000, ctrl_ff};
      WPWT_OFF_CMP:  rd_val = {16'h0000, cmp_ff};
      WPWT_OFF_CAP:  rd_val = {16'h0000, cap_ff};
      WPWT_OFF_CNT:  rd_val = {16'h0000, cnt_ff};
      WPWT_OFF_STAT: rd_val = {29'h00000000, event_window_pin, state_ff};
      default:       rd_val = 32'h00000000;
    endcase
  end

  // read data sampled in the setup cycle, held through the access
  always_ff @(posedge clk) begin
    if (rst) begin
      prdata_ff <= 32'h00000000;
    end else if (rd_setup) begin
      prdata_ff <= rd_val;
    end
  end

  // checks on the counting and capture behaviour
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic win_run;
  logic pul_run;
  assign win_run = (mode == WPWT_MODE_WINDOW) && (start != WPWT_START_STOP);
  assign pul_run = (mode == WPWT_MODE_PULSE) && (start == WPWT_START_EXT);

  a_window_count_inc: assert property (
    win_run && tick && pin_act && cnt_inc != cmp_ff |=> cnt_ff == $past(cnt_inc))
    else $error("window count did not advance");

  a_window_match_clear: assert property (
    win_run && tick && pin_act && cnt_inc == cmp_ff
    |=> cnt_ff == 16'h0000 && counter_match_irq ##1 !counter_match_irq)
    else $error("window match did not clear or pulse");

  a_window_gate_shut: assert property (
    win_run && !pin_act |=> $stable(cnt_ff))
    else $error("counter moved with window closed");

  a_soft_capture_copy: assert property (
    win_run && scap_wr |=> cap_ff == $past(cnt_ff))
    else $error("soft capture missed counter");

  a_pulse_wait_trig: assert property (
    mode == WPWT_MODE_PULSE && start != WPWT_START_STOP && state_ff == WPWT_ST_ARMED &&
    !(pul_run && trig_edge)
    |=> state_ff == WPWT_ST_ARMED && $stable(cnt_ff))
    else $error("pulse count began without trigger");

  a_pulse_tick_only: assert property (
    pul_run && state_ff == WPWT_ST_FIRST && !tick && !opp_edge |=> $stable(cnt_ff))
    else $error("pulse count moved without tick");

  a_opp_edge_capture: assert property (
    pul_run && state_ff == WPWT_ST_FIRST && opp_edge
    |=> cap_ff == $past(cnt_ff) && counter_match_irq)
    else $error("opposite edge capture missing");

  a_single_edge_clear: assert property (
    pul_run && state_ff == WPWT_ST_FIRST && opp_edge && single
    |=> cnt_ff == 16'h0000 && state_ff == WPWT_ST_ARMED)
    else $error("single edge capture did not clear");

  a_double_edge_recap: assert property (
    pul_run && state_ff == WPWT_ST_FIRST && opp_edge && !single
    |=> state_ff == WPWT_ST_SECOND && cap_ff == $past(cnt_ff))
    else $error("double edge sequence broken");

  a_second_edge_recap: assert property (
    pul_run && state_ff == WPWT_ST_SECOND && trig_edge
    |=> cap_ff == $past(cnt_ff) && counter_match_irq && state_ff == WPWT_ST_FIRST)
    else $error("trigger edge recapture missing");

  a_stop_clears_count: assert property (
    start == WPWT_START_STOP |=> cnt_ff == 16'h0000 && state_ff == WPWT_ST_ARMED)
    else $error("stop did not clear counter");

  c_window_match:  cover property (win_run && nxt_irq);
  c_single_capture: cover property (pul_run && opp_edge && single &&
                                    state_ff == WPWT_ST_FIRST);
  c_double_second: cover property (pul_run && trig_edge && state_ff == WPWT_ST_SECOND);
  c_soft_capture:  cover property (win_run && scap_wr);

endmodule // wpwt_timer

// ==== tb/wpwt_pin_model.sv ====
// far-side model: drives event_window_pin as a level or a pulse train.
// assumes a go pulse of one cycle; lengths counted in clk cycles.
`timescale 1ns/100ps
module wpwt_pin_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        go,
  input  wire logic        idle_lvl,
  input  wire logic [15:0] act_len,
  input  wire logic [15:0] idle_len,
  input  wire logic [3:0]  n_pulses,
  output logic             pin,
  output logic             busy
);
  logic        act_ff;
  logic [15:0] cnt_ff;
  logic [3:0]  left_ff;

  // pulse sequencer; lengths are kept long against the tick rate
  always_ff @(posedge clk) begin
    if (rst) begin
      busy    <= 1'b0;
      act_ff  <= 1'b0;
      cnt_ff  <= 16'h0000;
      left_ff <= 4'h0;
    end else if (go && !busy) begin
      busy    <= 1'b1;
      act_ff  <= 1'b1;
      cnt_ff  <= act_len - 16'h0001;
      left_ff <= n_pulses;
    end else if (busy) begin
      if (cnt_ff != 16'h0000) begin
        cnt_ff <= cnt_ff - 16'h0001;
      end else if (act_ff) begin
        act_ff <= 1'b0;
        cnt_ff <= idle_len - 16'h0001;
      end else if (left_ff > 4'h1) begin
        left_ff <= left_ff - 4'h1;
        act_ff  <= 1'b1;
        cnt_ff  <= act_len - 16'h0001;
      end else begin
        busy <= 1'b0;
      end
    end
  end

  // idle level between pulses, never left floating
  assign pin = (busy && act_ff) ? ~idle_lvl : idle_lvl;
endmodule // wpwt_pin_model

// ==== tb/tb_window_pulse_width_timer.sv ====
// testbench of the window / pulse width timer: apb tasks, directed tests.
// assumes wpwt_timer and the pin model; fast tick is clk/8.
`timescale 1ns/100ps
module tb_window_pulse_width_timer
  import wpwt_pkg::*;
;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, serr;
  logic        pin, irq, go, busy, idle_lvl;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, v;
  logic [15:0] act_len, idle_len;
  logic [3:0]  n_pulses;
  int          err_total, checks_done, n;
  int          cyc = 0;

  wpwt_timer dut_u (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .event_window_pin(pin),
    .counter_match_irq(irq));
  wpwt_pin_model pin_u (.clk(clk), .rst(rst), .go(go), .idle_lvl(idle_lvl),
    .act_len(act_len), .idle_len(idle_len), .n_pulses(n_pulses),
    .pin(pin), .busy(busy));

  // one compare; tol widens it where tick phase is unknown
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got, input int tol);
    checks_done++;
    if ((tol == 0) ? (got === exp) : (got + tol >= exp && got <= exp + tol)) begin
    end else begin
      err_total++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  // one apb transfer; read data and error taken at the pready edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  // cycles until the next irq pulse, 600 if none comes
  task automatic wait_irq(output int k);
    k = 0;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (irq !== 1'b1 && k < 600);
  endtask

  task automatic pulse(input logic l, input logic [15:0] a, input logic [15:0] b,
                       input logic [3:0] k);
    @(posedge clk);
    idle_lvl <= l; act_len <= a; idle_len <= b; n_pulses <= k; go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
  endtask

  task automatic drain;
    repeat (2) @(posedge clk);
    while (busy !== 1'b0) @(posedge clk);
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // hang guard, well above the roughly 1500 cycles needed
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      final_report;
    end
  end

  initial begin
    rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; go = 1'b0; idle_lvl = 1'b0; act_len = 16'h0;
    idle_len = 16'h0; n_pulses = 4'h0; err_total = 0; checks_done = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    apb(0, WPWT_OFF_CMP, 0); chk("cmp reset", 32'hffff, rd, 0);
    apb(0, WPWT_OFF_CAP, 0); chk("cap reset", 32'h0, rd, 0);
    apb(0, 8'h14, 0); chk("unmapped slverr", 32'h1, {31'h0, serr}, 0);
    $display("test reset done");
    // window mode, compare 5, tick every 8 cycles
    apb(1, WPWT_OFF_CMP, 32'h5);
    @(posedge clk); idle_lvl <= 1'b1;
    apb(1, WPWT_OFF_CTRL, 32'h14);
    wait_irq(n);
    wait_irq(n); chk("window period", 32'd40, n, 0);
    @(posedge clk); idle_lvl <= 1'b0;
    apb(0, WPWT_OFF_CNT, 0); v = rd;
    wait_irq(n); chk("gated no irq", 32'd600, n, 0);
    apb(0, WPWT_OFF_CNT, 0); chk("count held", v, rd, 0);
    chk("below compare", 32'h2, v, 2);
    apb(1, WPWT_OFF_CTRL, 32'h114);
    apb(0, WPWT_OFF_CAP, 0); chk("soft capture", v, rd, 0);
    apb(1, WPWT_OFF_CTRL, 32'h94);
    wait_irq(n);
    wait_irq(n); chk("active low period", 32'd40, n, 0);
    apb(1, WPWT_OFF_CTRL, 32'h84);
    apb(0, WPWT_OFF_CNT, 0); chk("stop clears", 32'h0, rd, 0);
    // open window but no internal rate selected: counter must stay put
    apb(1, WPWT_OFF_CTRL, 32'h96);
    repeat (40) @(posedge clk);
    apb(0, WPWT_OFF_CNT, 0); chk("no rate no count", 32'h0, rd, 0);
    apb(1, WPWT_OFF_CTRL, 32'h84);
    $display("test window done");
    // pulse mode, single edge, rising trigger, high for 80 cycles
    apb(1, WPWT_OFF_CTRL, 32'h75);
    repeat (40) @(posedge clk);
    apb(0, WPWT_OFF_CNT, 0); chk("armed idle", 32'h0, rd, 0);
    pulse(1'b0, 16'd80, 16'd40, 4'h1);
    wait_irq(n);
    apb(0, WPWT_OFF_CAP, 0); chk("high width", 32'd10, rd, 1);
    drain;
    apb(0, WPWT_OFF_CNT, 0); chk("single clear", 32'h0, rd, 0);
    apb(0, WPWT_OFF_STAT, 0); chk("back armed", 32'h0, rd & 32'h3, 0);
    $display("test single edge done");
    // double edge, falling trigger: low 40 then high 80, twice
    apb(1, WPWT_OFF_CTRL, 32'h0);
    @(posedge clk); idle_lvl <= 1'b1;
    apb(1, WPWT_OFF_CTRL, 32'hb5);
    pulse(1'b1, 16'd40, 16'd80, 4'h2);
    wait_irq(n);
    apb(0, WPWT_OFF_CAP, 0); chk("low width", 32'd5, rd, 1);
    wait_irq(n);
    apb(0, WPWT_OFF_CAP, 0); chk("period", 32'd15, rd, 1);
    drain;
    $display("test double edge done");
    // start codes other than external trigger must not run pulse mode
    for (int s = 0; s < 3; s++) begin
      apb(1, WPWT_OFF_CTRL, 32'h45 | (32'(s) << 4));
      pulse(1'b0, 16'd40, 16'd40, 4'h1);
      drain;
      apb(0, WPWT_OFF_CNT, 0); chk("no run", 32'h0, rd, 0);
    end
    $display("test start codes done");
    final_report;
  end
endmodule // tb_window_pulse_width_timer
